/* design/mfr_pkg.sv */
/*
  constants for the mac filter / retry / pad control block: register map, field positions, reset values, counts.
  assumes a 32-bit classic wishbone slave with word addressing by byte address.
*/
package mfr_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATION_HI = 8'h08;
  localparam logic [7:0] ADDR_STATION_LO = 8'h0c;
  localparam logic [7:0] ADDR_HASH_HI = 8'h10;
  localparam logic [7:0] ADDR_HASH_LO = 8'h14;
  localparam logic [7:0] ADDR_OFFLOAD_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  // main control field positions, and the offload control bit BIT_RX_COE
  localparam int BIT_HASH_ONLY = 15;
  localparam int BIT_HASH_PERFECT = 13;
  localparam int BIT_LATE_RETRY = 12;
  localparam int BIT_BROADCAST_REJECT_REJECT = 11;
  localparam int BIT_RETRY_DISABLE = 10;
  localparam int BIT_RESERVED9 = 9;
  localparam int BIT_PAD_STRIP = 8;
  localparam int BIT_RX_COE = 0;
  // writable bits of main control; bit 9 stays zero
  localparam logic [31:0] MAIN_CONTROL_MASK = 32'h0000_bd00;
  localparam logic [31:0] MAIN_CONTROL_RESET = 32'h0000_0000;
  localparam logic [47:0] STATION_RESET = 48'hffff_ffff_ffff;
  // irq status bits
  localparam int IRQ_RX_ACCEPT = 0;
  localparam int IRQ_RX_DROP = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_TX_RETRY_ERR = 3;
  localparam int IRQ_TX_LATE_COLL = 4;
  localparam int IRQ_WIDTH = 5;
  // transmit attempts
  localparam logic [4:0] MAX_ATTEMPTS = 5'd16;
  // pad strip threshold in bytes, and fcs size
  localparam logic [15:0] MIN_PAYLOAD = 16'd46;
  localparam logic [15:0] FCS_BYTES = 16'd4;
endpackage

/* design/mfr_addr_filter.sv */
/*
  destination address filter: perfect, hash and broadcast decisions for one frame.
  assumes the destination address is stable while rx_frame_valid is high; purely combinational.
*/
`timescale 1ns/100ps
module mfr_addr_filter (
  input wire logic [47:0] dest_addr, // destination, first transmitted byte in [7:0]
  input wire logic [47:0] station_addr, // programmed individual address
  input wire logic [63:0] hash_table, // multicast hash table
  input wire logic hash_or_perfect_select, // 1: hash filtering
  input wire logic hash_only_select, // 1: hash for individual too
  input wire logic broadcast_reject, // 1: drop broadcast
  output logic accept // frame passes
);
  logic is_multicast;
  logic is_broadcast;
  logic perfect_hit;
  logic hash_hit;
  logic [5:0] hash_index;

  // reflected crc32 over the address, low six bits index the table
  function automatic logic [5:0] mfr_hash(input logic [47:0] a);
    logic [31:0] crc;
    crc = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) begin
      crc = (crc[0] ^ a[i]) ? ((crc >> 1) ^ 32'hedb8_8320) : (crc >> 1);
    end
    return crc[5:0];
  endfunction

  always_comb begin
    is_multicast = dest_addr[0];
    is_broadcast = (dest_addr == 48'hffff_ffff_ffff);
    perfect_hit = (dest_addr == station_addr);
    hash_index = mfr_hash(dest_addr);
    hash_hit = hash_table[hash_index];
    if (is_broadcast) begin
      accept = !broadcast_reject;
    end else if (!hash_or_perfect_select) begin
      accept = perfect_hit;
    end else if (is_multicast) begin
      accept = hash_hit;
    end else if (hash_only_select) begin
      accept = hash_hit;
    end else begin
      accept = perfect_hit;
    end
  end
endmodule // mfr_addr_filter

/* design/mfr_control.sv */
/*
  mac control slice: main control register, receive filter decision, pad/fcs strip length, transmit retry policy.
  assumes a classic wishbone master on clock, and a frame path that presents one event per frame as one-cycle pulses.
*/
// Our own choices: register access over Wishbone and the placing of the registers.
// Functional notes
// - perfect mode: accept only station address match or broadcast
// - hash mode: multicast filtered by hash table
// - hash plus hash-only: individual hashed too
// - hash without hash-only: individual perfect filtered
// - late retry set: retransmit after late collision
// - late retry clear: abandon on late collision
// - late collision always reported in status
// - broadcast reject drops broadcast, else forward
// - retry disable: one attempt, retry error
// - otherwise up to sixteen attempts, then error
// - pad strip, length below 46: drop pad+fcs
// - length 46 or more passes unchanged
// - strip disabled: frames delivered unmodified
// - hash-only bit fifteen: imperfect for all
// - multicast when first destination bit set
`timescale 1ns/100ps
module mfr_control (
  input wire logic clock, // 20 mhz
  input wire logic nrst, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic rx_frame_valid, // pulse: destination and length ready
  input wire logic [47:0] rx_dest_addr, // received destination
  input wire logic [15:0] rx_length_field, // received length/type field
  input wire logic [15:0] rx_frame_bytes, // whole frame length incl. fcs
  output logic rx_decision_valid, // pulse: decision below valid
  output logic rx_accept, // frame goes to host
  output logic [15:0] rx_deliver_bytes, // bytes to hand on
  input wire logic tx_attempt_done, // pulse: attempt ended
  input wire logic tx_collision, // with done: collision seen
  input wire logic tx_late, // with done: collision was late
  output logic tx_retry, // pulse: send frame again
  output logic tx_frame_done, // pulse: frame finished
  output logic tx_status_retry_error, // status of finished frame
  output logic tx_status_late_collision, // status of finished frame
  output logic pad_strip_enable, // current strip setting
  output logic rx_checksum_offload_enable, // current offload setting
  output logic irq // level interrupt
);
  // ************************************************
  // reset and register bus
  // ************************************************
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire logic rst_n = rst_sync;

  logic [31:0] mac_main_control;
  logic [47:0] station_addr;
  logic [63:0] hash_table;
  logic [31:0] checksum_offload_control;
  logic [mfr_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [mfr_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [mfr_pkg::IRQ_WIDTH-1:0] irq_events;
  logic bus_req;
  logic wr_stb;
  logic rd_stb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = bus_req && wb_we_i;
  assign rd_stb = bus_req && !wb_we_i;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mac_main_control <= mfr_pkg::MAIN_CONTROL_RESET;
      station_addr <= mfr_pkg::STATION_RESET;
      hash_table <= '0;
      checksum_offload_control <= '0;
      irq_mask <= '0;
    end else if (wr_stb) begin
      unique case (wb_adr_i)
        mfr_pkg::ADDR_MAIN_CONTROL:
          mac_main_control <= merge(mac_main_control, wb_dat_i, wb_sel_i) & mfr_pkg::MAIN_CONTROL_MASK;
        mfr_pkg::ADDR_STATION_HI:
          station_addr[47:32] <= 16'(merge({16'h0000, station_addr[47:32]}, wb_dat_i, wb_sel_i));
        mfr_pkg::ADDR_STATION_LO: station_addr[31:0] <= merge(station_addr[31:0], wb_dat_i, wb_sel_i);
        mfr_pkg::ADDR_HASH_HI: hash_table[63:32] <= merge(hash_table[63:32], wb_dat_i, wb_sel_i);
        mfr_pkg::ADDR_HASH_LO: hash_table[31:0] <= merge(hash_table[31:0], wb_dat_i, wb_sel_i);
        mfr_pkg::ADDR_OFFLOAD_CONTROL:
          checksum_offload_control <= merge(checksum_offload_control, wb_dat_i, wb_sel_i) & 32'h0000_0001;
        mfr_pkg::ADDR_IRQ_MASK: irq_mask <= wb_dat_i[mfr_pkg::IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (rd_stb) begin
      unique case (wb_adr_i)
        mfr_pkg::ADDR_MAIN_CONTROL: wb_dat_o <= mac_main_control;
        mfr_pkg::ADDR_STATION_HI: wb_dat_o <= {16'h0000, station_addr[47:32]};
        mfr_pkg::ADDR_STATION_LO: wb_dat_o <= station_addr[31:0];
        mfr_pkg::ADDR_HASH_HI: wb_dat_o <= hash_table[63:32];
        mfr_pkg::ADDR_HASH_LO: wb_dat_o <= hash_table[31:0];
        mfr_pkg::ADDR_OFFLOAD_CONTROL: wb_dat_o <= checksum_offload_control;
        mfr_pkg::ADDR_IRQ_STATUS: wb_dat_o <= {{(32-mfr_pkg::IRQ_WIDTH){1'b0}}, irq_status};
        mfr_pkg::ADDR_IRQ_MASK: wb_dat_o <= {{(32-mfr_pkg::IRQ_WIDTH){1'b0}}, irq_mask};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ************************************************
  // interrupts
  // ************************************************
  // a read clears, but an event in the same cycle survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (rd_stb && wb_adr_i == mfr_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ************************************************
  // receive filter and pad strip
  // ************************************************
  logic filter_accept;
  logic hash_or_perfect_select;
  logic hash_only_select;
  logic broadcast_reject;
  logic late_collision_retry;
  logic retry_disable;
  assign hash_or_perfect_select = mac_main_control[mfr_pkg::BIT_HASH_PERFECT];
  assign hash_only_select = mac_main_control[mfr_pkg::BIT_HASH_ONLY];
  assign broadcast_reject = mac_main_control[mfr_pkg::BIT_BROADCAST_REJECT_REJECT];
  assign late_collision_retry = mac_main_control[mfr_pkg::BIT_LATE_RETRY];
  assign retry_disable = mac_main_control[mfr_pkg::BIT_RETRY_DISABLE];
  assign pad_strip_enable = mac_main_control[mfr_pkg::BIT_PAD_STRIP];
  assign rx_checksum_offload_enable = checksum_offload_control[mfr_pkg::BIT_RX_COE];

  mfr_addr_filter u_filter (
    .dest_addr(rx_dest_addr),
    .station_addr(station_addr),
    .hash_table(hash_table),
    .hash_or_perfect_select(hash_or_perfect_select),
    .hash_only_select(hash_only_select),
    .broadcast_reject(broadcast_reject),
    .accept(filter_accept)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_decision_valid <= 1'b0;
      rx_accept <= 1'b0;
      rx_deliver_bytes <= '0;
    end else begin
      rx_decision_valid <= rx_frame_valid;
      if (rx_frame_valid) begin
        rx_accept <= filter_accept;
        if (pad_strip_enable && rx_length_field < mfr_pkg::MIN_PAYLOAD) begin
          // header 14 + length, pad and fcs dropped
          rx_deliver_bytes <= rx_length_field + 16'd14;
        end else begin
          rx_deliver_bytes <= rx_frame_bytes;
        end
      end
    end
  end

  // ************************************************
  // transmit retry policy
  // ************************************************
  logic [4:0] attempts;
  logic give_up;
  logic do_retry;
  // a late collision on an earlier attempt still belongs to this frame's status
  logic late_seen;
  logic late_event;
  always_comb begin
    give_up = 1'b0;
    do_retry = 1'b0;
    if (tx_attempt_done && tx_collision) begin
      if (retry_disable) begin
        give_up = 1'b1;
      end else if (tx_late && !late_collision_retry) begin
        give_up = 1'b1;
      end else if (attempts + 5'd1 >= mfr_pkg::MAX_ATTEMPTS) begin
        give_up = 1'b1;
      end else begin
        do_retry = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      attempts <= '0;
      tx_retry <= 1'b0;
      tx_frame_done <= 1'b0;
      tx_status_retry_error <= 1'b0;
      tx_status_late_collision <= 1'b0;
      late_seen <= 1'b0;
      late_event <= 1'b0;
    end else begin
      tx_retry <= do_retry;
      tx_frame_done <= tx_attempt_done && !do_retry;
      late_event <= tx_attempt_done && tx_collision && tx_late;
      if (tx_attempt_done && !do_retry) begin
        attempts <= '0;
        late_seen <= 1'b0;
        // retry error only when attempts were exhausted or disabled
        tx_status_retry_error <= give_up && (retry_disable || !(tx_late && !late_collision_retry));
        tx_status_late_collision <= late_seen || (tx_collision && tx_late);
      end else if (do_retry) begin
        attempts <= attempts + 5'd1;
        late_seen <= late_seen || tx_late;
      end
    end
  end

  assign irq_events = {late_event, tx_frame_done && tx_status_retry_error,
                       tx_frame_done, rx_decision_valid && !rx_accept, rx_decision_valid && rx_accept};

  // ************************************************
  // checks
  // ************************************************
  chk_retry_disable_one: assert property (@(posedge clock) disable iff (!rst_n)
    tx_attempt_done && tx_collision && retry_disable |=> tx_frame_done && tx_status_retry_error && !tx_retry)
    else $error("retry disabled but frame retried");
  chk_late_abandon: assert property (@(posedge clock) disable iff (!rst_n)
    tx_attempt_done && tx_collision && tx_late && !late_collision_retry |=> tx_frame_done && !tx_retry)
    else $error("late collision not abandoned");
  chk_late_status: assert property (@(posedge clock) disable iff (!rst_n)
    tx_attempt_done && tx_collision && tx_late && !do_retry |=> tx_status_late_collision)
    else $error("late collision not reported");
  chk_late_retry: assert property (@(posedge clock) disable iff (!rst_n)
    tx_attempt_done && tx_collision && tx_late && late_collision_retry && !retry_disable && attempts < 5'd15
    |=> tx_retry) else $error("late collision not retried");
  chk_attempt_limit: assert property (@(posedge clock) disable iff (!rst_n)
    attempts < mfr_pkg::MAX_ATTEMPTS) else $error("attempt count past limit");
  chk_pad_strip: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && pad_strip_enable && rx_length_field < 16'd46 |=> rx_deliver_bytes == $past(rx_length_field) + 16'd14)
    else $error("short frame not stripped");
  chk_no_strip: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && !pad_strip_enable |=> rx_deliver_bytes == $past(rx_frame_bytes))
    else $error("frame modified with strip off");
  chk_broadcast_reject_reject: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && rx_dest_addr == 48'hffff_ffff_ffff |=> rx_accept == !$past(broadcast_reject))
    else $error("broadcast decision wrong");
  chk_perfect_mode: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && !hash_or_perfect_select && rx_dest_addr != 48'hffff_ffff_ffff
    |=> rx_accept == ($past(rx_dest_addr) == $past(station_addr))) else $error("perfect filter wrong");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    !mac_main_control[mfr_pkg::BIT_RESERVED9]) else $error("reserved bit set");
  chk_long_frame: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && pad_strip_enable && rx_length_field >= 16'd46 |=> rx_deliver_bytes == $past(rx_frame_bytes))
    else $error("long frame modified");
  chk_hash_mcast: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && hash_or_perfect_select && rx_dest_addr[0] && rx_dest_addr != 48'hffff_ffff_ffff
    && hash_table == 64'h0 |=> !rx_accept) else $error("multicast passed empty hash table");
  chk_ia_perfect: assert property (@(posedge clock) disable iff (!rst_n)
    rx_frame_valid && hash_or_perfect_select && !hash_only_select && !rx_dest_addr[0]
    |=> rx_accept == ($past(rx_dest_addr) == $past(station_addr))) else $error("individual address not perfect");
  cov_retry: cover property (@(posedge clock) disable iff (!rst_n) tx_retry);
  cov_retry_err: cover property (@(posedge clock) disable iff (!rst_n) tx_frame_done && tx_status_retry_error);
  cov_strip: cover property (@(posedge clock) disable iff (!rst_n) rx_frame_valid && pad_strip_enable);
  cov_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
  cov_late: cover property (@(posedge clock) disable iff (!rst_n) late_event && tx_retry);
endmodule // mfr_control

/* test/mfr_phy_model.sv */
/*
  far-side model of the mii frame path: hands over received frame headers and transmit attempt outcomes.
  assumes the block's own clock; the bench steers it through its two tasks.
*/
`timescale 1ns/100ps
module mfr_phy_model (
  input wire logic clock, // block clock
  output logic rx_frame_valid, // header pulse
  output logic [47:0] rx_dest_addr, // destination, first byte in [7:0]
  output logic [15:0] rx_length_field, // length/type field
  output logic [15:0] rx_frame_bytes, // frame size with fcs
  output logic tx_attempt_done, // attempt outcome pulse
  output logic tx_collision, // collision seen
  output logic tx_late // collision was late
);
  initial begin
    rx_frame_valid = 1'b0;
    rx_dest_addr = 48'h0;
    rx_length_field = 16'h0;
    rx_frame_bytes = 16'h0;
    tx_attempt_done = 1'b0;
    tx_collision = 1'b0;
    tx_late = 1'b0;
  end

  // gap lets the bench make the far side answer slowly
  task automatic rx_frame(input logic [47:0] dest, input logic [15:0] len, input logic [15:0] bytes,
                          input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    rx_frame_valid <= 1'b1;
    rx_dest_addr <= dest;
    rx_length_field <= len;
    rx_frame_bytes <= bytes;
    @(posedge clock);
    rx_frame_valid <= 1'b0;
    // released lines show the inverse so a stale capture cannot pass
    rx_dest_addr <= ~dest;
    rx_length_field <= ~len;
    rx_frame_bytes <= ~bytes;
  endtask

  task automatic tx_attempt(input logic coll, input logic late);
    @(posedge clock);
    tx_attempt_done <= 1'b1;
    tx_collision <= coll;
    tx_late <= late;
    @(posedge clock);
    tx_attempt_done <= 1'b0;
    tx_collision <= ~coll;
    tx_late <= ~late;
  endtask
endmodule // mfr_phy_model

/* test/tb_top.sv */
/*
  self-checking bench for mfr_control: register access, filter table, pad strip, retry policy, interrupt.
  assumes mfr_pkg constants and the partner model mfr_phy_model on the frame path.
*/
`timescale 1ns/100ps
module tb_top;
  localparam logic [47:0] ST = 48'h1122_5566_7788;
  localparam logic [47:0] OT = 48'h1122_5566_7688;
  localparam logic [47:0] MC = 48'h0000_0000_0001;
  localparam logic [47:0] BC = 48'hffff_ffff_ffff;
  localparam logic [15:0] LT = 16'h0800;
  typedef struct packed {
    logic [15:0] ctrl; logic hash; logic [47:0] dest; logic [15:0] len; logic [15:0] bytes;
    logic acc; logic [15:0] dlv;
  } mfr_row_s;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, rx_frame_valid, rx_decision_valid, rx_accept, tx_attempt_done, tx_collision, tx_late;
  logic [47:0] rx_dest_addr;
  logic [15:0] rx_length_field, rx_frame_bytes, rx_deliver_bytes;
  logic tx_retry, tx_frame_done, tx_status_retry_error, tx_status_late_collision;
  logic pad_strip_enable, rx_checksum_offload_enable, irq;
  int failures = 0;
  int checked = 0;
  mfr_row_s rows [15] = '{
    '{16'h0000, 1'b1, ST, LT, 16'd64, 1'b1, 16'd64}, '{16'h0000, 1'b1, OT, LT, 16'd64, 1'b0, 16'd64},
    '{16'h0000, 1'b1, MC, LT, 16'd64, 1'b0, 16'd64}, '{16'h2000, 1'b1, MC, LT, 16'd64, 1'b1, 16'd64},
    '{16'h2000, 1'b0, MC, LT, 16'd64, 1'b0, 16'd64}, '{16'h2000, 1'b1, OT, LT, 16'd64, 1'b0, 16'd64},
    '{16'h2000, 1'b0, ST, LT, 16'd64, 1'b1, 16'd64}, '{16'ha000, 1'b1, OT, LT, 16'd64, 1'b1, 16'd64},
    '{16'ha000, 1'b0, ST, LT, 16'd64, 1'b0, 16'd64}, '{16'h0000, 1'b0, BC, LT, 16'd64, 1'b1, 16'd64},
    '{16'h0800, 1'b0, BC, LT, 16'd64, 1'b0, 16'd64}, '{16'h0800, 1'b1, ST, LT, 16'd64, 1'b1, 16'd64},
    '{16'h0100, 1'b0, ST, 16'd45, 16'd64, 1'b1, 16'd59}, '{16'h0100, 1'b0, ST, 16'd46, 16'd64, 1'b1, 16'd64},
    '{16'h0000, 1'b0, ST, 16'd10, 16'd64, 1'b1, 16'd64}};

  always #25 clock = ~clock;

  mfr_control u_mfr_control (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_frame_valid(rx_frame_valid), .rx_dest_addr(rx_dest_addr),
    .rx_length_field(rx_length_field), .rx_frame_bytes(rx_frame_bytes), .rx_decision_valid(rx_decision_valid),
    .rx_accept(rx_accept), .rx_deliver_bytes(rx_deliver_bytes), .tx_attempt_done(tx_attempt_done),
    .tx_collision(tx_collision), .tx_late(tx_late), .tx_retry(tx_retry), .tx_frame_done(tx_frame_done),
    .tx_status_retry_error(tx_status_retry_error), .tx_status_late_collision(tx_status_late_collision),
    .pad_strip_enable(pad_strip_enable), .rx_checksum_offload_enable(rx_checksum_offload_enable), .irq(irq));

  mfr_phy_model u_mfr_phy_model (.clock(clock), .rx_frame_valid(rx_frame_valid), .rx_dest_addr(rx_dest_addr),
    .rx_length_field(rx_length_field), .rx_frame_bytes(rx_frame_bytes), .tx_attempt_done(tx_attempt_done),
    .tx_collision(tx_collision), .tx_late(tx_late));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ack is sampled at the rising edge; read data is taken and the request dropped at that same edge
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic tx(input logic coll, input logic late, input logic [3:0] exp, input logic stat);
    u_mfr_phy_model.tx_attempt(coll, late);
    @(negedge clock);
    chk("tx_retry_done", {tx_retry, tx_frame_done}, exp[3:2]);
    if (stat) chk("tx_status", {tx_status_retry_error, tx_status_late_collision}, exp[1:0]);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    tally_and_finish();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    mfr_row_s r;
    repeat (12) @(posedge clock);
    chk("outs_in_reset", {wb_ack_o, rx_decision_valid, tx_retry, tx_frame_done, irq}, 48'h0);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    bus(1'b0, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0, q);
    chk("ctrl_reset", q, mfr_pkg::MAIN_CONTROL_RESET);
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'hffff_ffff, q);
    bus(1'b0, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0, q);
    chk("ctrl_mask", q, 32'h0000_bd00);
    bus(1'b1, 8'h20, 32'hffff_ffff, q);
    bus(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    bus(1'b1, mfr_pkg::ADDR_STATION_HI, 32'h0000_1122, q);
    bus(1'b1, mfr_pkg::ADDR_STATION_LO, 32'h5566_7788, q);
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, {16'h0, r.ctrl}, q);
      bus(1'b1, mfr_pkg::ADDR_HASH_HI, {32{r.hash}}, q);
      bus(1'b1, mfr_pkg::ADDR_HASH_LO, {32{r.hash}}, q);
      u_mfr_phy_model.rx_frame(r.dest, r.len, r.bytes, i % 3);
      @(negedge clock);
      chk("rx_decision", {rx_decision_valid, rx_accept}, {1'b1, r.acc});
      if (r.acc) chk("rx_deliver", rx_deliver_bytes, r.dlv);
      chk("pad_strip", pad_strip_enable, r.ctrl[8]);
    end
    $display("test filter table done");
    // offload only with strip off
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0, q);
    bus(1'b1, mfr_pkg::ADDR_OFFLOAD_CONTROL, 32'h1, q);
    chk("offload_on", rx_checksum_offload_enable, 1'b1);
    bus(1'b1, mfr_pkg::ADDR_OFFLOAD_CONTROL, 32'h0, q);
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0000_0400, q);
    tx(1'b1, 1'b0, 4'b0110, 1'b1);
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0, q);
    for (int i = 1; i < 16; i++) tx(1'b1, 1'b0, 4'b1000, 1'b0);
    tx(1'b1, 1'b0, 4'b0110, 1'b1);
    tx(1'b0, 1'b0, 4'b0100, 1'b1);
    tx(1'b1, 1'b1, 4'b0101, 1'b1);
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0000_1000, q);
    bus(1'b0, mfr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    tx(1'b1, 1'b1, 4'b1000, 1'b0);
    bus(1'b0, mfr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    chk("late_event", q[4], 1'b1);
    tx(1'b0, 1'b0, 4'b0101, 1'b1);
    $display("test transmit done");
    bus(1'b1, mfr_pkg::ADDR_MAIN_CONTROL, 32'h0, q);
    bus(1'b1, mfr_pkg::ADDR_IRQ_MASK, 32'h1, q);
    bus(1'b0, mfr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    @(negedge clock);
    chk("irq_idle", irq, 1'b0);
    u_mfr_phy_model.rx_frame(ST, LT, 16'd64, 0);
    repeat (2) @(negedge clock);
    chk("irq_raised", irq, 1'b1);
    bus(1'b1, mfr_pkg::ADDR_IRQ_MASK, 32'h0, q);
    @(negedge clock);
    chk("irq_masked", irq, 1'b0);
    bus(1'b1, mfr_pkg::ADDR_IRQ_MASK, 32'h1, q);
    @(negedge clock);
    chk("irq_sticky", irq, 1'b1);
    bus(1'b0, mfr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    chk("irq_status", q, 32'h1);
    @(negedge clock);
    chk("irq_cleared", irq, 1'b0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule // tb_top
